// ### hdl/dept_map.svh
// constants for the dual edge pwm timer: widths, counts, reset values, edge codes
// assumes inclusion by bare name from the package and design modules
//
// Contract
// - cycle match resets count, sets period
// - single-edge outputs go high each cycle start unless their match is zero
// - one extra match sets single-edge falling position
// - two matches set double-edge rise and fall
// - seven matches, six single or three double
// - per match: continue, stop or reset, interrupt
// - count from clock or capture input edges
// - any period and width, shared rate
// - released match values apply at cycle start
// - plain 32-bit timer with 32-bit prescaler
// - channel zero capture input as count source
`ifndef DEPT_MAP_SVH
`define DEPT_MAP_SVH
`define DEPT_CNT_W      32
`define DEPT_NUM_MATCH  7
`define DEPT_NUM_OUT    6
`define DEPT_CNT_RESET  32'h0000_0000
`define DEPT_MATCH_RESET 32'h0000_0000
// capture edge select encoding
`define DEPT_EDGE_RISE  2'h1
`define DEPT_EDGE_FALL  2'h2
`define DEPT_EDGE_BOTH  2'h3
`endif

// ### hdl/dept_pkg.sv
// types shared by the pwm timer modules
// assumes the map header is on the include path
`default_nettype none
`include "dept_map.svh"
package dept_pkg;
  typedef logic [`DEPT_CNT_W-1:0] dept_word_t;
  typedef enum logic [1:0]
  {
    DEPT_RUN_OFF  = 2'b00,
    DEPT_RUN_ON   = 2'b01,
    DEPT_RUN_HALT = 2'b10
  } dept_run_e;
endpackage
`default_nettype wire

// ### hdl/dept_edge_tick.sv
// count source: prescaled clock or edges of the channel zero capture input
// assumes the capture input is already synchronous to i_clk
`default_nettype none
`include "dept_map.svh"
module dept_edge_tick
  import dept_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_run,
  input  wire logic       i_counter_mode,
  input  wire logic [1:0] i_edge_sel,
  input  wire logic       i_capture,
  input  wire dept_word_t i_prescale,
  output logic            o_tick
);
  logic       cap_reg;
  logic       edge_hit;
  logic       src_tick;
  dept_word_t pre_reg;

  // previous capture level; follows the pin even in reset, so a pulled-up
  // idle input never looks like an edge on the first cycle after reset
  always_ff @(posedge i_clk)
  begin
    cap_reg <= i_capture;
  end

  // counter mode counts chosen capture edges instead of clocks
  always_comb
  begin
    case (i_edge_sel)
      `DEPT_EDGE_RISE: edge_hit = i_capture & ~cap_reg;
      `DEPT_EDGE_FALL: edge_hit = ~i_capture & cap_reg;
      `DEPT_EDGE_BOTH: edge_hit = i_capture ^ cap_reg;
      default:         edge_hit = 1'b0;
    endcase
    src_tick = i_counter_mode ? edge_hit : 1'b1;
  end

  // prescaler: terminal value yields one tick and wraps to zero
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n || !i_run)
      pre_reg <= `DEPT_CNT_RESET;
    else if (src_tick)
      pre_reg <= (pre_reg >= i_prescale) ? `DEPT_CNT_RESET : pre_reg + 32'h1;
  end

  assign o_tick = i_run && src_tick && (pre_reg >= i_prescale);
endmodule
`default_nettype wire

// ### hdl/dept_shadow.sv
// one match channel: shadow value written by software, active value copied
// on release at the start of a cycle so edges never glitch mid-period
`default_nettype none
`include "dept_map.svh"
module dept_shadow
  import dept_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_wr,
  input  wire dept_word_t i_wdata,
  input  wire logic       i_release,
  input  wire logic       i_apply,
  output dept_word_t      o_active,
  output logic            o_pending
);
  dept_word_t shadow_reg;

  // shadow holds software value until applied
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      shadow_reg <= `DEPT_MATCH_RESET;
    else if (i_wr)
      shadow_reg <= i_wdata;
  end

  // pending: a write that software has released; set wins over apply
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_pending <= 1'b0;
    else if (i_release)
      o_pending <= 1'b1;
    else if (i_apply)
      o_pending <= 1'b0;
  end

  // copy at cycle boundary, in step with outputs, or at once while the timer is stopped
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_active <= `DEPT_MATCH_RESET;
    else if (i_apply && o_pending)
      o_active <= shadow_reg;
  end
endmodule
`default_nettype wire

// ### hdl/dept_pwm_timer.sv
// dual edge pwm timer: 32-bit prescaled count, seven match channels,
// six outputs, single edge or (outputs 2 to 6) double edge, per-match interrupt/stop/reset actions
// assumes all control inputs are synchronous to i_clk and held static
// except the write and release strobes, which are one-cycle pulses
`default_nettype none
`include "dept_map.svh"
module dept_pwm_timer
  import dept_pkg::*;
(
  input  wire logic                        i_clk,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_enable,
  input  wire logic                        i_count_reset,
  input  wire logic                        i_pwm_mode,
  input  wire logic                        i_counter_mode,
  input  wire logic [1:0]                  i_edge_sel,
  input  wire logic                        i_capture,
  input  wire dept_word_t                  i_prescale,
  input  wire logic [`DEPT_NUM_MATCH-1:0]  i_match_irq_en,
  input  wire logic [`DEPT_NUM_MATCH-1:0]  i_match_reset_en,
  input  wire logic [`DEPT_NUM_MATCH-1:0]  i_match_stop_en,
  input  wire logic [`DEPT_NUM_OUT:1]      i_double_edge,
  input  wire logic [`DEPT_NUM_OUT:1]      i_out_en,
  input  wire logic [`DEPT_NUM_MATCH-1:0]  i_match_wr,
  input  wire dept_word_t                  i_match_wdata,
  input  wire logic [`DEPT_NUM_MATCH-1:0]  i_match_release,
  input  wire logic [`DEPT_NUM_MATCH-1:0]  i_flag_clr,
  output dept_word_t                       o_count,
  output logic                             o_running,
  output logic [`DEPT_NUM_MATCH-1:0]       o_match_flag,
  output logic [`DEPT_NUM_MATCH-1:0]       o_release_pending,
  output logic [`DEPT_NUM_OUT:1]           o_pwm
);
  dept_run_e   run_reg;
  dept_run_e   run_next;
  logic        tick;
  logic        cycle_start;
  logic        any_reset;
  logic        any_stop;
  logic [`DEPT_NUM_MATCH-1:0] hit;
  logic [`DEPT_NUM_OUT:1]     pwm_next;
  dept_word_t  match_val [`DEPT_NUM_MATCH];

  // run state: enable starts, a stop match halts until enable is cycled
  always_comb
  begin
    case (run_reg)
      DEPT_RUN_OFF:  run_next = i_enable ? DEPT_RUN_ON : DEPT_RUN_OFF;
      DEPT_RUN_ON:
      begin
        if (!i_enable)
          run_next = DEPT_RUN_OFF;
        else if (any_stop)
          run_next = DEPT_RUN_HALT;
        else
          run_next = DEPT_RUN_ON;
      end
      DEPT_RUN_HALT: run_next = i_enable ? DEPT_RUN_HALT : DEPT_RUN_OFF;
      default:       run_next = DEPT_RUN_OFF;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      run_reg <= DEPT_RUN_OFF;
    else
      run_reg <= run_next;
  end

  assign o_running = (run_reg == DEPT_RUN_ON);

  // tick source and prescaler
  dept_edge_tick u_tick
  (
    .i_clk          (i_clk),
    .i_reset_n      (i_reset_n),
    .i_run          (o_running && !i_count_reset),
    .i_counter_mode (i_counter_mode),
    .i_edge_sel     (i_edge_sel),
    .i_capture      (i_capture),
    .i_prescale     (i_prescale),
    .o_tick         (tick)
  );

  // one shadowed match per channel
  genvar g;
  generate
    for (g = 0; g < `DEPT_NUM_MATCH; g++)
    begin : g_match
      dept_shadow u_shadow
      (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_wr      (i_match_wr[g]),
        .i_wdata   (i_match_wdata),
        .i_release (i_match_release[g]),
        .i_apply   (cycle_start || !o_running),
        .o_active  (match_val[g]),
        .o_pending (o_release_pending[g])
      );
      // a match is seen on the tick that would move the count past the value
      assign hit[g] = tick && (o_count == match_val[g]);
    end
  endgenerate

  // in pwm mode the cycle channel always resets; else per-channel choice
  assign any_reset = |(hit & i_match_reset_en) || (i_pwm_mode && hit[0]);
  assign any_stop  = |(hit & i_match_stop_en);
  assign cycle_start = i_pwm_mode && hit[0];

  // 32-bit count advancing on each prescaled tick
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n || i_count_reset)
      o_count <= `DEPT_CNT_RESET;
    else if (any_reset)
      o_count <= `DEPT_CNT_RESET;
    else if (tick)
      o_count <= o_count + 32'h1;
  end

  // sticky match flags: a new match wins over a clear in the same cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_match_flag <= '0;
    else
      o_match_flag <= (o_match_flag & ~i_flag_clr) | (hit & i_match_irq_en);
  end

  // output edges: single edge uses cycle start and its own match,
  // double edge uses match n-1 to rise and match n to fall
  always_comb
  begin
    pwm_next = o_pwm;
    for (int n = 1; n <= `DEPT_NUM_OUT; n++)
    begin
      if (i_double_edge[n] && n >= 2)
      begin
        if (hit[n-1])
          pwm_next[n] = 1'b1;
        if (hit[n])
          pwm_next[n] = 1'b0;
      end
      else
      begin
        if (cycle_start && match_val[n] != `DEPT_MATCH_RESET)
          pwm_next[n] = 1'b1;
        if (hit[n] || (cycle_start && match_val[n] == `DEPT_MATCH_RESET))
          pwm_next[n] = 1'b0;
      end
      if (!i_out_en[n] || !i_pwm_mode)
        pwm_next[n] = 1'b0;
    end
  end

  // outputs registered; up to six outputs from seven matches
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      o_pwm <= '0;
    else
      o_pwm <= pwm_next;
  end
endmodule
`default_nettype wire

// ### dv/dept_pwm_timer_sva.sv
// port checks on the pwm timer: reset, count steps, edges, flags
// assumes a bind into dept_pwm_timer by port names
`default_nettype none
module dept_pwm_timer_sva
  import dept_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       i_count_reset,
  input wire logic       i_pwm_mode,
  input wire logic [6:0] i_match_release,
  input wire logic [6:0] i_flag_clr,
  input wire dept_word_t o_count,
  input wire logic       o_running,
  input wire logic [6:0] o_match_flag,
  input wire logic [6:0] o_release_pending,
  input wire logic [6:1] o_pwm
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain, so clock and reset are given once
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  rst_clear_a: assert property (disable iff (1'b0)
    !i_reset_n |=> o_count == '0 && o_pwm == '0 && o_match_flag == '0)
    else $error("reset left outputs set");
  count_step_a: assert property (
    o_count != $past(o_count) |-> o_count == $past(o_count) + 32'h1 || o_count == '0)
    else $error("count jumped");
  wrap_rise_a: assert property ($rose(o_pwm[1]) |-> o_count == '0)
    else $error("single edge rose mid cycle");
  pwm_off_a: assert property (!i_pwm_mode ##1 !i_pwm_mode |-> o_pwm == '0)
    else $error("output active outside pwm mode");
  flag_hold_a: assert property (o_match_flag[0] && !i_flag_clr[0] |=> o_match_flag[0])
    else $error("flag dropped");
  flag_clear_a: assert property (
    $fell(o_match_flag[0]) |-> $past(i_flag_clr[0]) || !$past(i_reset_n))
    else $error("flag cleared without request");
  release_src_a: assert property (
    $rose(o_release_pending[2]) |-> $past(i_match_release[2]))
    else $error("pending without release");
  halt_hold_a: assert property (!o_running && !i_count_reset |=> $stable(o_count))
    else $error("count moved while stopped");
endmodule
bind dept_pwm_timer dept_pwm_timer_sva u_dept_pwm_timer_sva (.i_clk, .i_reset_n,
  .i_count_reset, .i_pwm_mode, .i_match_release, .i_flag_clr, .o_count, .o_running,
  .o_match_flag, .o_release_pending, .o_pwm);
`default_nettype wire

// ### dv/dept_load_model.sv
// load on one pwm output: measures high time and period in clocks
// assumes the output is sampled on the timer clock
`default_nettype none
module dept_load_model
(
  input  wire logic i_clk,
  input  wire logic i_drive,
  output int        o_high,
  output int        o_period
);
  timeunit 1ns;
  timeprecision 1ps;
  int   h;
  int   p;
  logic last;
  // runs restart on each edge, so a stale first cycle is soon forgotten
  always_ff @(posedge i_clk)
  begin
    last <= i_drive;
    h <= i_drive ? h + 1 : 0;
    p <= (i_drive && !last) ? 1 : p + 1;
    if (i_drive && !last)
      o_period <= p;
    if (!i_drive && last)
      o_high <= h;
  end
endmodule
`default_nettype wire

// ### dv/test_dual_edge_pwm_timer.sv
// bench for the pwm timer: edges, release, stop, capture counting
// assumes the design, checker and load model are compiled with it
`default_nettype none
`include "dept_map.svh"
module test_dual_edge_pwm_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import dept_pkg::*;
  logic       i_clk = 0, i_reset_n = 0, i_enable = 0, i_count_reset = 0;
  logic       i_pwm_mode = 0, i_counter_mode = 0, i_capture = 0;
  logic [1:0] i_edge_sel = 2'h0;
  dept_word_t i_prescale = '0, i_match_wdata = '0, o_count;
  logic [6:0] i_match_irq_en = '0, i_match_reset_en = '0, i_match_stop_en = '0;
  logic [6:0] i_match_wr = '0, i_match_release = '0, i_flag_clr = '0;
  logic [6:0] o_match_flag, o_release_pending;
  logic [6:1] i_double_edge = '0, i_out_en = '0, o_pwm;
  logic       o_running;
  int         n_mismatch = 0, compares = 0, hi, per;
  dept_pwm_timer u_dept_pwm_timer (.i_clk, .i_reset_n, .i_enable, .i_count_reset,
    .i_pwm_mode, .i_counter_mode, .i_edge_sel, .i_capture, .i_prescale, .i_match_irq_en,
    .i_match_reset_en, .i_match_stop_en, .i_double_edge, .i_out_en, .i_match_wr,
    .i_match_wdata, .i_match_release, .i_flag_clr, .o_count, .o_running, .o_match_flag,
    .o_release_pending, .o_pwm);
  dept_load_model u_dept_load_model (.i_clk, .i_drive(o_pwm[2]), .o_high(hi), .o_period(per));
  // 50 MHz
  initial
    forever #10 i_clk = ~i_clk;
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge i_clk);
  endtask
  // strobes get a quiet cycle after them so no bit is set twice in a step
  task automatic wr(int ch, dept_word_t v, logic rel);
    i_match_wr[ch] = 1'b1;
    i_match_release[ch] = rel;
    i_match_wdata = v;
    cyc(1);
    i_match_wr = '0;
    i_match_release = '0;
    cyc(1);
  endtask
  // stopped timer takes releases at once, then it runs five cycles of 8
  task automatic start(dept_word_t m0, m1, m2, logic [6:1] dbl);
    i_enable = 0;
    i_count_reset = 1;
    i_double_edge = dbl;
    cyc(1);
    wr(0, m0, 1);
    wr(1, m1, 1);
    wr(2, m2, 1);
    i_count_reset = 0;
    i_enable = 1;
    cyc(40);
  endtask
  task automatic t_shape();
    i_pwm_mode = 1;
    i_out_en = 6'h3f;
    start(7, 0, 4, 6'h00);
    chk("period", per, 8);
    chk("single high", hi, 5);
    chk("idle outputs", o_pwm[6:3], 0);
    start(7, 2, 5, 6'h02);
    chk("positive high", hi, 3);
    start(7, 5, 2, 6'h02);
    chk("negative high", hi, 5);
    chk("shared period", per, 8);
  endtask
  task automatic t_release();
    start(7, 0, 4, 6'h00);
    wr(2, 1, 0);
    cyc(20);
    chk("unreleased high", hi, 5);
    for (int k = 0; k < 20 && o_count !== 1; k++)
      cyc(1);
    i_match_release[2] = 1'b1;
    cyc(1);
    i_match_release = '0;
    chk("pending", o_release_pending[2], 1);
    cyc(20);
    chk("pending done", o_release_pending[2], 0);
    chk("released high", hi, 2);
  endtask
  task automatic t_stop();
    dept_word_t c;
    i_out_en = '0;
    i_match_irq_en = 7'h7f;
    i_match_stop_en = 7'h01;
    start(7, 0, 4, 6'h00);
    c = o_count;
    chk("halted", o_running, 0);
    chk("flag", o_match_flag[0], 1);
    cyc(5);
    chk("held count", o_count, c);
    i_flag_clr = 7'h01;
    cyc(1);
    i_flag_clr = '0;
    cyc(1);
    chk("flag cleared", o_match_flag[0], 0);
    i_match_stop_en = '0;
  endtask
  // prescale 1 halves the edges: none gives 0, rise and fall give 3, both 6
  task automatic t_count();
    i_pwm_mode = 0;
    i_counter_mode = 1;
    i_prescale = 1;
    i_out_en = 6'h3f;
    for (int e = 0; e <= `DEPT_EDGE_BOTH; e++)
    begin
      i_edge_sel = 2'(e);
      start(7, 0, 4, 6'h00);
      repeat (6)
      begin
        i_capture = 1;
        cyc(2);
        i_capture = 0;
        cyc(2);
      end
      cyc(3);
      chk("edge count", o_count, e == 0 ? 0 : (e == 3 ? 6 : 3));
    end
    chk("outputs off", o_pwm, 0);
    i_counter_mode = 0;
    i_prescale = 0;
    i_match_reset_en = 7'h02;
    start(7, 2, 0, 6'h00);
    repeat (3)
    begin
      chk("bounded count", o_count <= 2, 1);
      cyc(1);
    end
  endtask
  // mid-run reset: flags set by the zero and reset matches must all clear
  task automatic t_reset();
    chk("flags set", o_match_flag, 7'h7e);
    i_reset_n = 0;
    cyc(2);
    i_reset_n = 1;
    chk("reset flags", o_match_flag, 0);
    chk("reset run", o_running, 0);
    chk("reset count", o_count, 0);
    chk("reset outputs", o_pwm, 0);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    cyc(20);
    i_reset_n = 1;
    cyc(1);
    chk("reset count", o_count, 0);
    t_shape();
    t_release();
    t_stop();
    t_count();
    t_reset();
    tally_and_finish();
  end
  // about 700 cycles are needed
  initial
  begin
    repeat (3000) @(posedge i_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
